// [hw/tc_defines.svh]
// Constants of the temperature conversion readout core.
// Assumes a 125 MHz core clock.
`ifndef TC_DEFINES_SVH
`define TC_DEFINES_SVH

`define TC_CMD_CONVERT    8'h44
`define TC_RESULT_RESET   16'h0550
`define TC_CONFIG_RESET   8'h60
`define TC_ALARM_HI_RESET 8'h00
`define TC_ALARM_LO_RESET 8'h00
`define TC_RES_LSB        5
`define TC_RES_MSB        6
`define TC_RES_9          2'h0
`define TC_RES_10         2'h1
`define TC_RES_11         2'h2
`define TC_RES_12         2'h3
`define TC_CLK_MHZ        125
`define TC_CONV_TIME_MS   750
`define TC_CONV_CYCLES    (`TC_CONV_TIME_MS * 1000 * `TC_CLK_MHZ)
`define TC_CNT_W          27
`define TC_NV_HI          0
`define TC_NV_LO          1
`define TC_NV_CFG         2
`define TC_FAMILY_CODE    8'h5a
`define TC_SERIAL_NUMBER  48'h0123456789ab

`endif

// [hw/tc_pkg.sv]
// Types of the temperature conversion readout core.
// Assumes tc_defines.svh is on the include path.
`include "tc_defines.svh"

package tc_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_STORE   = 2'b11
  } conv_state_t;

  typedef struct packed
  {
    conv_state_t        state;
    logic [15:0]        result;
    logic [7:0]         alarm_hi;
    logic [7:0]         alarm_lo;
    logic [7:0]         config_reg;
    logic [2:0][7:0]    nv;
    logic               poll_armed;
    logic               busy;
    logic               done;
    logic               dq_oe;
    logic               timer_start;
    logic [`TC_CNT_W-1:0] timer_load;
    logic [63:0]        serial;
  } core_state_t;

endpackage

// [hw/conv_timer.sv]
// Down counter that times one temperature conversion.
// Assumes start is a one-cycle pulse and count is at least one.
`timescale 1ns/10ps
`include "tc_defines.svh"

module conv_timer
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 start,
  input  wire logic [`TC_CNT_W-1:0] count,
  output logic                      expired
);

  logic [`TC_CNT_W-1:0] remaining;
  logic                 running;

  // Counts down the loaded figure and pulses expired once it has counted down to one.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      remaining <= '0;
      running   <= 1'b0;
      expired   <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        remaining <= count;
        running   <= 1'b1;
      end
      else if (running)
      begin
        if (remaining <= `TC_CNT_W'(1))
        begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        else
        begin
          remaining <= remaining - `TC_CNT_W'(1);
        end
      end
    end
  end

endmodule // conv_timer

// [hw/temp_readout.sv]
// Temperature conversion and result store behind a single-wire line.
// Assumes a line layer that delivers whole command bytes and read slot windows,
// and an analog front end that presents a 12-bit sample in sixteenths of a degree.
//
// Functional notes
// - Resolution selectable at 9, 10, 11, 12 bits.
// - Power-up resolution is 12 bits.
// - Idle until command 44h starts a conversion.
// - Store result, then return to idle.
// - Externally powered: read slots answer busy/done.
// - Result is 16-bit sign-extended two's complement.
// - Sign bits zero positive, one negative.
// - Lower resolutions leave low bits undefined; the core clears them to zero.
// - Alarm limits and configuration bytes accessible.
// - Alarm and configuration bytes kept nonvolatile.
// - Unique 64-bit serial code identifies device.
// - Line driven only open-drain, pull low.
// - 12-bit conversion completes within 750 ms; core takes 750 ms plus 3 clock cycles.
// - Result reads 0550h until first conversion.
`timescale 1ns/10ps
`include "tc_defines.svh"

module temp_readout
#(
  parameter int CONV_CYCLES = `TC_CONV_CYCLES,
  parameter logic [7:0]  FAMILY_CODE   = `TC_FAMILY_CODE,
  parameter logic [47:0] SERIAL_NUMBER = `TC_SERIAL_NUMBER
)
(
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_BYTE,
  input  wire logic        READ_SLOT,
  input  wire logic        SUPPLY_PIN,
  input  wire logic [11:0] SENSE_SAMPLE,
  input  wire logic        WR_ALARM_HIGH,
  input  wire logic        WR_ALARM_LOW,
  input  wire logic        WR_CONFIG,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        NV_COMMIT,
  input  wire logic        NV_RECALL,
  output logic [15:0]      TEMP_RESULT,
  output logic [7:0]       ALARM_HIGH,
  output logic [7:0]       ALARM_LOW,
  output logic [7:0]       CONFIG,
  output logic             BUSY,
  output logic             CONV_DONE,
  output logic             DQ_OUT,
  output logic             DQ_OE,
  output logic [63:0]      SERIAL_CODE
);
  import tc_pkg::*;

  core_state_t r;
  core_state_t next_r;
  logic        timer_expired;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding of the resolution field.

  // Keeps the valid low bits of a result for the selected resolution.
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    case (res)
      `TC_RES_9:  res_mask = 16'hfff8;
      `TC_RES_10: res_mask = 16'hfffc;
      `TC_RES_11: res_mask = 16'hfffe;
      default:    res_mask = 16'hffff;
    endcase
  endfunction

  // Halves the conversion time for each bit of resolution given up.
  function automatic logic [`TC_CNT_W-1:0] res_cycles(input logic [1:0] res);
    logic [`TC_CNT_W-1:0] full;
    full = `TC_CNT_W'(CONV_CYCLES);
    case (res)
      `TC_RES_9:  res_cycles = full >> 3;
      `TC_RES_10: res_cycles = full >> 2;
      `TC_RES_11: res_cycles = full >> 1;
      default:    res_cycles = full;
    endcase
    if (res_cycles == '0)
    begin
      res_cycles = `TC_CNT_W'(1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion timer.

  conv_timer u_timer
  (
    .clk     (CORE_CLK),
    .srst    (SRST),
    .start   (r.timer_start),
    .count   (r.timer_load),
    .expired (timer_expired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    logic [1:0]  res;
    logic [15:0] word;
    res         = r.config_reg[`TC_RES_MSB:`TC_RES_LSB];
    word        = {{4{SENSE_SAMPLE[11]}}, SENSE_SAMPLE};
    next_r      = r;
    next_r.timer_start = 1'b0;
    next_r.done = 1'b0;

    case (r.state)
      ST_IDLE:
      begin
        if (CMD_VALID && (CMD_BYTE == `TC_CMD_CONVERT))
        begin
          next_r.state       = ST_CONVERT;
          next_r.busy        = 1'b1;
          next_r.poll_armed  = 1'b1;
          next_r.timer_start = 1'b1;
          next_r.timer_load  = res_cycles(res);
        end
      end
      ST_CONVERT:
      begin
        if (timer_expired)
        begin
          next_r.state = ST_STORE;
        end
      end
      ST_STORE:
      begin
        next_r.result = word & res_mask(res);
        next_r.busy   = 1'b0;
        next_r.done   = 1'b1;
        next_r.state  = ST_IDLE;
      end
      default:
      begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Scratchpad bytes may not change the resolution of a running conversion.
    if (WR_ALARM_HIGH)
    begin
      next_r.alarm_hi = WR_DATA;
    end
    if (WR_ALARM_LOW)
    begin
      next_r.alarm_lo = WR_DATA;
    end
    if (WR_CONFIG && !r.busy)
    begin
      next_r.config_reg = WR_DATA;
    end

    if (NV_COMMIT)
    begin
      next_r.nv[`TC_NV_HI]  = r.alarm_hi;
      next_r.nv[`TC_NV_LO]  = r.alarm_lo;
      next_r.nv[`TC_NV_CFG] = r.config_reg;
    end
    else if (NV_RECALL && !r.busy)
    begin
      next_r.alarm_hi   = r.nv[`TC_NV_HI];
      next_r.alarm_lo   = r.nv[`TC_NV_LO];
      next_r.config_reg = r.nv[`TC_NV_CFG];
    end

    // Busy answers pull the line low; a line-powered part never answers.
    next_r.dq_oe = READ_SLOT && r.poll_armed && r.busy && SUPPLY_PIN;
    next_r.serial = {8'h00, SERIAL_NUMBER, FAMILY_CODE};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; the nonvolatile bytes are deliberately left out of reset.

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      r.state       <= ST_IDLE;
      r.result      <= `TC_RESULT_RESET;
      r.alarm_hi    <= `TC_ALARM_HI_RESET;
      r.alarm_lo    <= `TC_ALARM_LO_RESET;
      r.config_reg  <= `TC_CONFIG_RESET;
      r.poll_armed  <= 1'b0;
      r.busy        <= 1'b0;
      r.done        <= 1'b0;
      r.dq_oe       <= 1'b0;
      r.timer_start <= 1'b0;
      r.timer_load  <= '0;
      r.serial      <= '0;
      r.nv          <= next_r.nv;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign TEMP_RESULT = r.result;
  assign ALARM_HIGH  = r.alarm_hi;
  assign ALARM_LOW   = r.alarm_lo;
  assign CONFIG      = r.config_reg;
  assign BUSY        = r.busy;
  assign CONV_DONE   = r.done;
  assign DQ_OUT      = 1'b0;
  assign DQ_OE       = r.dq_oe;
  assign SERIAL_CODE = r.serial;

endmodule // temp_readout

// [bench/line_model.sv]
// Open-drain data line with weak and strong pullup on the master side.
// Assumes the core only pulls the line low.
`timescale 1ns/10ps
module line_model
(
  input  wire logic dq_oe,
  input  wire logic strong_pu,
  output logic      dq_level
);
  assign dq_level = strong_pu ? 1'b1 : !dq_oe;
endmodule // line_model

// [bench/temp_readout_monitor.sv]
// Concurrent checks on the ports of the temperature readout core.
// Assumes the bind below hands on CONV_CYCLES.
`timescale 1ns/10ps
module temp_readout_monitor
#(
  parameter int CONV_CYCLES = 64
)
(
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        CMD_VALID,
  input wire logic [7:0]  CMD_BYTE,
  input wire logic        READ_SLOT,
  input wire logic        SUPPLY_PIN,
  input wire logic [15:0] TEMP_RESULT,
  input wire logic [7:0]  CONFIG,
  input wire logic        BUSY,
  input wire logic        CONV_DONE,
  input wire logic        DQ_OUT,
  input wire logic        DQ_OE
);
  localparam int CMAX = CONV_CYCLES + 3;
  logic go;
  assign go = CMD_VALID && CMD_BYTE == 8'h44 && !BUSY;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  a_start_busy: assert property (go |=> BUSY)
    else $error("no busy");
  a_idle_stays: assert property (!BUSY && !go |=> !BUSY)
    else $error("busy unasked");
  a_done_ends: assert property (CONV_DONE |-> !BUSY && $past(BUSY))
    else $error("bad done");
  a_result_holds: assert property (!CONV_DONE |-> $stable(TEMP_RESULT))
    else $error("result moved");
  a_sign_bits: assert property (TEMP_RESULT[15:11] == {5{TEMP_RESULT[11]}})
    else $error("sign bits");
  a_low_bits: assert property (CONV_DONE |-> (TEMP_RESULT[2:0] & (3'h7 >> CONFIG[6:5])) == 3'h0)
    else $error("low bits");
  a_conv_bound: assert property ($rose(BUSY) |-> ##[1:CMAX] CONV_DONE)
    else $error("conv too long");
  a_poll_busy: assert property (READ_SLOT && BUSY && SUPPLY_PIN |=> DQ_OE)
    else $error("no poll low");
  a_line_free: assert property (!BUSY || !SUPPLY_PIN |=> !DQ_OE)
    else $error("line held");
  a_open_drain: assert property (DQ_OUT == 1'b0)
    else $error("drives high");
  c_done: cover property (CONV_DONE);
  c_poll: cover property (READ_SLOT && DQ_OE);
  c_retry: cover property (CMD_VALID && BUSY);
endmodule // temp_readout_monitor
bind temp_readout temp_readout_monitor #(.CONV_CYCLES(CONV_CYCLES)) temp_readout_monitor_i
  (.CORE_CLK, .SRST, .CMD_VALID, .CMD_BYTE, .READ_SLOT, .SUPPLY_PIN, .TEMP_RESULT, .CONFIG,
   .BUSY, .CONV_DONE, .DQ_OUT, .DQ_OE);

// [bench/temp_readout_tb_top.sv]
// Self-checking bench of the temperature readout core.
// Assumes the core, its package, the line model and the monitor are compiled.
`timescale 1ns/10ps
module temp_readout_tb_top;
  logic clk = 0, srst = 1, cv = 0, rs = 0, sup = 1, wh = 0, wl = 0, wc = 0, nc = 0, nr = 0, spu = 0;
  logic [7:0] cb = 0, wd = 0, ah, al, cfg;
  logic [11:0] smp = 0;
  logic [15:0] res;
  logic busy, done, oe, dq;
  logic [63:0] ser;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #4 clk = ~clk;
  // Family and serial values are arbitrary.
  temp_readout #(.CONV_CYCLES(64), .FAMILY_CODE(8'hc3), .SERIAL_NUMBER(48'h0a0b0c0d0e0f)) temp_readout_i
  (.CORE_CLK(clk), .SRST(srst), .CMD_VALID(cv), .CMD_BYTE(cb), .READ_SLOT(rs), .SUPPLY_PIN(sup),
   .SENSE_SAMPLE(smp), .WR_ALARM_HIGH(wh), .WR_ALARM_LOW(wl), .WR_CONFIG(wc), .WR_DATA(wd),
   .NV_COMMIT(nc), .NV_RECALL(nr), .TEMP_RESULT(res), .ALARM_HIGH(ah), .ALARM_LOW(al), .CONFIG(cfg),
   .BUSY(busy), .CONV_DONE(done), .DQ_OUT(), .DQ_OE(oe), .SERIAL_CODE(ser));
  line_model line_model_i (.dq_oe(oe), .strong_pu(spu), .dq_level(dq));
  ////////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task t_reset;
    chk({res, cfg}, 24'h055060);
    chk(ser, {8'h00, 48'h0a0b0c0d0e0f, 8'hc3});
    rs = 1;
    tick(2);
    chk({busy, oe, dq}, 3'b001);
    rs = 0;
  endtask
  task t_regs;
    wd = 8'h19;
    wh = 1;
    tick(1);
    wh = 0;
    wl = 1;
    wd = 8'hf6;
    tick(1);
    wl = 0;
    nc = 1;
    tick(1);
    nc = 0;
    wh = 1;
    wd = 8'h00;
    tick(1);
    wh = 0;
    nr = 1;
    tick(1);
    nr = 0;
    tick(1);
    chk({ah, al, cfg}, 24'h19f660);
  endtask
  task t_conv(input logic [1:0] r, input logic [11:0] s, input logic p);
    logic [15:0] prev;
    int k;
    int n;
    prev = res;
    n = 64 >> (3 - r);
    wc = 1;
    wd = {1'b0, r, 5'h1f};
    smp = s;
    sup = p;
    tick(1);
    wc = 0;
    cv = 1;
    cb = 8'h44;
    tick(1);
    wc = 1;
    wd = 8'h00;
    rs = p;
    spu = !p;
    tick(2);
    cv = 0;
    wc = 0;
    k = 2;
    chk({busy, oe, dq, res, cfg[6:5]}, {1'b1, p, !p, prev, r});
    while (done !== 1'b1 && k < 200)
    begin
      tick(1);
      k++;
    end
    chk(k >= n && k <= n + 3, 1'b1);
    spu = 0;
    tick(1);
    rs = 0;
    chk({busy, done, oe, dq, res}, {4'b0001, {{4{s[11]}}, s} & ~(16'h0007 >> r)});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      close_out;
    end
  end
  initial
  begin
    tick(3);
    srst = 0;
    tick(1);
    t_reset;
    t_regs;
    t_conv(2'h3, 12'hfa7, 1'b1);
    t_conv(2'h2, 12'h197, 1'b0);
    t_conv(2'h1, 12'hf5f, 1'b1);
    t_conv(2'h0, 12'h197, 1'b1);
    close_out;
  end
endmodule // temp_readout_tb_top
